// ---- bst_pkg.sv ----
// constants, codes and carrier types of the boundary-scan test port
package bst_pkg;

  // ----------------------------------------------------------------
  // register sizes
  // ----------------------------------------------------------------
  localparam int IR_W       = 3;            // instruction register width
  localparam int ID_W       = 32;           // identification register width
  localparam int BSR_LEN    = 109;          // boundary chain length
  localparam int BALL_N     = 108;          // cells fed from balls
  localparam int OE_CELL    = 108;          // index of cell 109, output enable
  localparam int TMS_RESET_EDGES = 5;       // tms-high edges that reach reset

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] INS_EXTEST  = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE  = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE  = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS  = 3'h7;
  localparam logic [IR_W-1:0] IR_RESET    = INS_IDCODE;
  localparam logic [1:0]      IR_CAPTURE  = 2'h1;   // fixed low-bit pattern

  // ----------------------------------------------------------------
  // identification code fields
  // ----------------------------------------------------------------
  localparam logic [2:0]  ID_REVISION = 3'h0;
  localparam logic [16:0] ID_PART     = 17'h00a5a;  // arbitrary value
  localparam logic [10:0] ID_VENDOR   = 11'h2a3;    // arbitrary value
  localparam logic        ID_START    = 1'b1;
  localparam logic [ID_W-1:0] ID_CODE = {ID_REVISION, ID_PART, ID_VENDOR, ID_START};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [BSR_LEN-1:0] BSR_RESET = 109'h0;  // oe cell low: q floats
  localparam logic [2:0]         PIN_RESET = 3'h3;    // tck low, tms/tdi high

  // ----------------------------------------------------------------
  // controller states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

  // test pins as they arrive from the board
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;

  // what the boundary cells present toward the balls
  typedef struct packed {
    logic              drive;   // cells own the output pins
    logic              qOe;     // data output bus drivers on
    logic [BALL_N-1:0] data;    // preload values for the pins
  } bst_ball_ctl_t;

endpackage

// ---- bst_sync.sv ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module bst_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // bst_sync

// ---- bst_tap.sv ----
// boundary-scan test access port: controller, instruction, bypass, id, boundary chain
//
// What this block does
// - inputs sampled on tck rise; tdo changes only on tck fall.
// - tms and tdi pulled high internally, open pins read as one.
// - five tck rises with tms high reset the test logic only.
// - power-up reset puts tdo in high impedance, memory unaffected.
// - serial data enters every register at msb, leaves at lsb.
// - exactly one register sits between tdi and tdo, chosen by instruction.
// - three-bit instruction shifts in shift-ir, takes effect at update-ir.
// - reset and test-logic-reset load the identification instruction.
// - capture-ir loads binary 01 into the two low instruction bits.
// - bypass is one bit, used under bypass, cleared at capture.
// - boundary chain captures all balls, shifts between tdi and tdo.
// - identification instruction captures a fixed 32-bit code for shifting.
// - output-float sample uses boundary chain and floats q until update-ir.
// - sample/preload captures balls, latches shifted preload data in parallel.
// - external test drives preload data on pins, boundary chain shifts.
// - cell 109 enables q drivers under external test; default floats.
// - cell 109 latches at update-dr, only under sample/preload or external test.
// - codes 000 extest, 001 id, 010 float-sample, 100 sample, 111 bypass.
// - chain has 109 cells; last is internal output-enable cell.
`timescale 1ns/1ps
module bst_tap (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire bst_pkg::bst_pins_t    pins,
  input  wire logic [bst_pkg::BALL_N-1:0] ballIn,
  output logic                       tdoOut,
  output logic                       tdoOe,
  output logic                       tmsPullEn,
  output logic                       tdiPullEn,
  output bst_pkg::bst_ball_ctl_t     ballCtl,
  output bst_pkg::bst_state_t        tapState
);
  import bst_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bst_pins_t            pinSync;
  logic                 tckPrev_q;
  logic                 tckRise;
  logic                 tckFall;
  bst_state_t           state_q;
  bst_state_t           state_d;
  logic [IR_W-1:0]      irShift_q;
  logic [IR_W-1:0]      instr_q;
  logic                 bypass_q;
  logic [ID_W-1:0]      idShift_q;
  logic [BSR_LEN-1:0]   bsrShift_q;
  logic [BSR_LEN-1:0]   bsrUpd_q;
  logic                 tdo_q;
  logic                 tdoOe_q;
  bst_ball_ctl_t        ballCtl_q;
  logic                 selBsr;
  logic                 selId;
  logic                 selByp;
  logic                 mayPreload;
  logic                 inShiftIr;
  logic                 inShiftDr;
  logic                 drBit;
  logic                 serialBit;
  logic [BSR_LEN-1:0]   bsrCapture;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // tck, tms and tdi cross into clk before any logic looks at them
  bst_sync #(
    .W   (3),
    .RST (PIN_RESET)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (pins),
    .q    (pinSync)
  );

  // weak pull-ups on the mode-select and data-in pins
  assign tmsPullEn = 1'b1;
  assign tdiPullEn = 1'b1;

  // previous synchronised tck, for edge finding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tckPrev_q <= 1'b0;
    end else begin
      tckPrev_q <= pinSync.tck;
    end
  end

  // a held-low tck gives no edges, so the port stays idle
  assign tckRise = pinSync.tck & ~tckPrev_q;
  assign tckFall = ~pinSync.tck & tckPrev_q;

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  // next state from the sampled mode select
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET:  state_d = pinSync.tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_d = pinSync.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = pinSync.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = pinSync.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_d = pinSync.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = pinSync.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = pinSync.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = pinSync.tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = pinSync.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = pinSync.tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_d = pinSync.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_d = pinSync.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = pinSync.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = pinSync.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = pinSync.tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = pinSync.tms ? ST_SEL_DR : ST_IDLE;
      default:   state_d = ST_RESET;
    endcase
  end

  // state steps only on a tck rise; any state reaches reset in five tms-high rises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  assign tapState = state_q;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  // reserved codes fall back to bypass so one path always stands
  assign selBsr     = (instr_q == INS_EXTEST) | (instr_q == INS_SAMPLEZ)
                    | (instr_q == INS_SAMPLE);
  assign selId      = (instr_q == INS_IDCODE);
  assign selByp     = ~selBsr & ~selId;
  assign mayPreload = (instr_q == INS_EXTEST) | (instr_q == INS_SAMPLE);
  assign inShiftIr  = (state_q == ST_SH_IR);
  assign inShiftDr  = (state_q == ST_SH_DR);

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // shift stage: capture fixed pattern, shift msb-in
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irShift_q <= IR_RESET;
    end else if (tckRise) begin
      case (state_q)
        ST_CAP_IR: irShift_q <= {irShift_q[IR_W-1:2], IR_CAPTURE};
        ST_SH_IR:  irShift_q <= {pinSync.tdi, irShift_q[IR_W-1:1]};
        default:   irShift_q <= irShift_q;
      endcase
    end
  end

  // current instruction changes only at update-ir or reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      instr_q <= IR_RESET;
    end else if (tckRise) begin
      case (state_q)
        ST_RESET:  instr_q <= IR_RESET;
        ST_UPD_IR: instr_q <= irShift_q;
        default:   instr_q <= instr_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bypass and identification registers
  // ----------------------------------------------------------------
  // bypass: single bit, zero at capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bypass_q <= 1'b0;
    end else if (tckRise && selByp) begin
      case (state_q)
        ST_CAP_DR: bypass_q <= 1'b0;
        ST_SH_DR:  bypass_q <= pinSync.tdi;
        default:   bypass_q <= bypass_q;
      endcase
    end
  end

  // identification: hardwired code captured, then shifted toward tdo
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idShift_q <= ID_CODE;
    end else if (tckRise && selId) begin
      case (state_q)
        ST_CAP_DR: idShift_q <= ID_CODE;
        ST_SH_DR:  idShift_q <= {pinSync.tdi, idShift_q[ID_W-1:1]};
        default:   idShift_q <= idShift_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // boundary scan register
  // ----------------------------------------------------------------
  // capture: every ball; the oe cell has no ball and keeps its shift value
  assign bsrCapture = {bsrShift_q[OE_CELL], ballIn};

  // shift stage of all 109 cells
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bsrShift_q <= BSR_RESET;
    end else if (tckRise && selBsr) begin
      case (state_q)
        ST_CAP_DR: bsrShift_q <= bsrCapture;
        ST_SH_DR:  bsrShift_q <= {pinSync.tdi, bsrShift_q[BSR_LEN-1:1]};
        default:   bsrShift_q <= bsrShift_q;
      endcase
    end
  end

  // preload stage: latched at update-dr under sample/preload or external test
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bsrUpd_q <= BSR_RESET;
    end else if (tckRise && mayPreload && state_q == ST_UPD_DR) begin
      bsrUpd_q <= bsrShift_q;
    end
  end

  // ----------------------------------------------------------------
  // ball control
  // ----------------------------------------------------------------
  // follows the current instruction and the preload stage, so changes land at update-ir, update-dr or test-logic-reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ballCtl_q <= '{drive: 1'b0, qOe: 1'b1, data: '0};
    end else begin
      ballCtl_q.drive <= (instr_q == INS_EXTEST);
      ballCtl_q.data  <= bsrUpd_q[BALL_N-1:0];
      case (instr_q)
        INS_EXTEST:  ballCtl_q.qOe <= bsrUpd_q[OE_CELL];
        INS_SAMPLEZ: ballCtl_q.qOe <= 1'b0;
        default:     ballCtl_q.qOe <= 1'b1;
      endcase
    end
  end

  assign ballCtl = ballCtl_q;

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // lsb of the selected register feeds tdo
  assign drBit     = selBsr ? bsrShift_q[0] : (selId ? idShift_q[0] : bypass_q);
  assign serialBit = inShiftIr ? irShift_q[0] : drBit;

  // tdo and its enable move only on a tck fall
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tdo_q   <= 1'b0;
      tdoOe_q <= 1'b0;
    end else if (tckFall) begin
      tdo_q   <= serialBit;
      tdoOe_q <= inShiftIr | inShiftDr;
    end
  end

  assign tdoOut = tdo_q;
  assign tdoOe  = tdoOe_q;

endmodule // bst_tap

// ---- bst_tap_monitor.sv ----
// concurrent checks on the ports of the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_monitor (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire bst_pkg::bst_pins_t          pins,
  input wire logic [bst_pkg::BALL_N-1:0] ballIn,
  input wire logic                        tdoOut,
  input wire logic                        tdoOe,
  input wire logic                        tmsPullEn,
  input wire logic                        tdiPullEn,
  input wire bst_pkg::bst_ball_ctl_t      ballCtl,
  input wire bst_pkg::bst_state_t         tapState
);
  import bst_pkg::*;
  logic       tckLast_q;
  logic [2:0] tmsCount_q;
  logic       tckRise;
  logic       fiveHigh;
  // ---------------------------------------------------------------
  // tck rise finder and run of tms-high rises
  // ---------------------------------------------------------------
  assign tckRise  = pins.tck && !tckLast_q;
  assign fiveHigh = tckRise && pins.tms && (tmsCount_q >= 3'(TMS_RESET_EDGES - 1));
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tckLast_q  <= 1'b0;
      tmsCount_q <= 3'h0;
    end else begin
      tckLast_q <= pins.tck;
      if (tckRise) begin
        tmsCount_q <= !pins.tms ? 3'h0 : (tmsCount_q == 3'(TMS_RESET_EDGES)) ? 3'(TMS_RESET_EDGES)
                    : tmsCount_q + 3'h1;
      end
    end
  end
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  pull_up_a: assert property (tmsPullEn && tdiPullEn)
    else $error("tms or tdi pull-up off");
  reset_values_a: assert property ($rose(rstn) |-> tapState == ST_RESET && !tdoOe && ballCtl.qOe && !ballCtl.drive)
    else $error("port not idle after reset");
  tdo_on_fall_a: assert property (($changed(tdoOut) || $changed(tdoOe)) |-> !pins.tck)
    else $error("tdo moved while tck high");
  state_on_rise_a: assert property ($changed(tapState) |-> pins.tck)
    else $error("controller stepped while tck low");
  oe_in_shift_a: assert property ($rose(tdoOe) |-> tapState == ST_SH_DR || tapState == ST_SH_IR)
    else $error("tdo driven outside shift");
  tms_reset_a: assert property (fiveHigh |-> ##[1:6] tapState == ST_RESET)
    else $error("five tms-high rises did not reset");
  ctl_at_update_a: assert property ($changed(ballCtl) |-> tapState inside {ST_UPD_IR, ST_UPD_DR, ST_RESET, ST_IDLE, ST_SEL_DR})
    else $error("pin control changed outside update");
  idle_exit_a: assert property (($changed(tapState) && $past(tapState) == ST_IDLE) |-> tapState == ST_SEL_DR)
    else $error("bad step out of idle");
  reset_exit_a: assert property (($changed(tapState) && $past(tapState) == ST_RESET) |-> tapState == ST_IDLE)
    else $error("bad step out of reset");
endmodule // bst_tap_monitor

bind bst_tap bst_tap_monitor i_mon (.clk(clk), .rstn(rstn), .pins(pins), .ballIn(ballIn), .tdoOut(tdoOut),
  .tdoOe(tdoOe), .tmsPullEn(tmsPullEn), .tdiPullEn(tdiPullEn), .ballCtl(ballCtl), .tapState(tapState));

// ---- bst_master.sv ----
// test master model: drives tck, tms and tdi, samples tdo
`timescale 1ns/1ps
module bst_master (
  input  wire logic          clk,
  input  wire logic          tdoPin,
  output bst_pkg::bst_pins_t pins
);
  import bst_pkg::*;
  // tck starts low and stands low between frames; tms and tdi start at pulled-up level
  initial pins = PIN_RESET;
  // one 400 ns tck period: tms/tdi set while low, held across the rise
  task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
    pins.tms = tmsV;
    pins.tdi = tdiV;
    repeat (4) @(posedge clk);
    #1;
    tdoV = tdoPin;
    pins.tck = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    pins.tck = 1'b0;
  endtask
endmodule // bst_master

// ---- tb_boundary_scan_tap.sv ----
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_boundary_scan_tap;
  import bst_pkg::*;
  localparam logic [BALL_N-1:0] BALLS = {27{4'h6}};
  localparam logic [BALL_N-1:0] PRE   = {27{4'h9}};
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  bst_pins_t     pins;
  logic          tdoOut;
  logic          tdoOe;
  logic          tdoLast_q = 1'b0;
  logic          tdoPin;
  logic          tmsPullEn;
  logic          tdiPullEn;
  logic [BALL_N-1:0] ballIn = BALLS;
  bst_ball_ctl_t ballCtl;
  bst_state_t    tapState;
  int            fail_count = 0;
  int            samples_checked = 0;
  logic          b;
  logic [2:0]    c3;
  logic [127:0]  d;
  always #25 clk = ~clk;
  // released tdo line shows the inverse of its last driven level
  always @(posedge clk) if (tdoOe) tdoLast_q <= tdoOut;
  assign tdoPin = tdoOe ? tdoOut : ~tdoLast_q;
  bst_tap i_dut (.clk(clk), .rstn(rstn), .pins(pins), .ballIn(ballIn), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .tmsPullEn(tmsPullEn), .tdiPullEn(tdiPullEn), .ballCtl(ballCtl), .tapState(tapState));
  bst_master i_master (.clk(clk), .tdoPin(tdoPin), .pins(pins));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // tms sequence sent first bit first, tdi held high
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      i_master.step(seq[i], 1'b1, b);
    end
  endtask
  // idle to idle through shift-ir; only documented codes are ever loaded
  task automatic shift_ir(input logic [2:0] code);
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      i_master.step(i == 2, code[i], b);
      c3[i] = b;
    end
    walk(8'h01, 2);
  endtask
  task automatic shift_dr(input int n, input logic [127:0] din);
    d = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      i_master.step(i == n - 1, din[i], b);
      d[i] = b;
    end
    walk(8'h01, 2);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset_id();
    check(tapState, ST_RESET, "state after reset");
    check({tdoOe, ballCtl.drive, ballCtl.qOe}, 3'h1, "port not idle");
    check({tmsPullEn, tdiPullEn}, 2'h3, "pull-ups off");
    walk(8'h00, 1);
    shift_dr(32, '0);
    check(d[31:0], ID_CODE, "id code");
  endtask
  task automatic sc_extest_default();
    shift_ir(INS_EXTEST);
    check(c3[1:0], 2'h1, "ir capture pattern");
    check({ballCtl.drive, ballCtl.qOe}, 2'h2, "extest default");
  endtask
  task automatic sc_bypass();
    shift_ir(INS_BYPASS);
    check(ballCtl.drive, 1'b0, "bypass owns pins");
    shift_dr(4, 128'hb);
    check(d[3:0], 4'h6, "bypass path");
  endtask
  task automatic sc_preload();
    shift_ir(INS_SAMPLE);
    shift_dr(109, {19'h0, 1'b1, PRE});
    check(d[107:0], BALLS, "ball snapshot");
    check({ballCtl.drive, ballCtl.data}, {1'b0, PRE}, "preload latched");
    shift_ir(INS_EXTEST);
    check(ballCtl, {1'b1, 1'b1, PRE}, "extest drives preload");
    shift_ir(INS_SAMPLEZ);
    check({ballCtl.drive, ballCtl.qOe}, 2'h0, "float sample");
    // balls move, so this capture must be a fresh snapshot
    ballIn = ~BALLS;
    shift_dr(109, '0);
    check({ballCtl.qOe, d[107:0]}, {1'b0, ~BALLS}, "float held");
    shift_ir(INS_EXTEST);
    check(ballCtl, {1'b1, 1'b1, PRE}, "preload under float");
  endtask
  task automatic sc_tms_reset();
    walk(8'h1f, 5);
    check(tapState, ST_RESET, "five tms high");
    check({ballCtl.drive, ballCtl.qOe}, 2'h1, "reset instruction");
    walk(8'h00, 1);
    shift_dr(32, '0);
    check(d[31:0], ID_CODE, "id after tms reset");
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    sc_reset_id();
    sc_extest_default();
    sc_bypass();
    sc_preload();
    sc_tms_reset();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("MISMATCH %0t run did not finish", $time);
    tally_and_finish();
  end
endmodule // tb_boundary_scan_tap
